// ### verilog/qpc_core.sv
`timescale 1ns/1ns
`include "qpc_regs.svh"
module qpc_core
  import qpc_pkg::*;
#(
  parameter int IO_WIDTH = 8,
  parameter int PC_WIDTH = 16
)(
  input wire logic clk, // 20 MHz system clock
  input wire logic rstn, // Asynchronous power-on reset, active low
  input wire qpc_wb_req_type wb_req, // Wishbone request from master
  output qpc_wb_rsp_type wb_rsp, // Wishbone answer
  input wire logic osc_input_pin, // Oscillator input, asynchronous
  input wire logic supply_ok, // Supply above trip point, asynchronous
  input wire logic brown_out_det, // Brown-out detector, active high
  input wire logic master_clear_pin_n, // External reset pin, active low
  input wire logic watchdog_reset, // Watchdog time-out, active high
  input wire logic [1:0] oscillator_select_bits, // Configuration strap
  input wire logic ext_exec_mode, // Strap: processor mode runs external code
  output logic [PC_WIDTH-1:0] prog_addr, // Program memory address
  input wire logic [15:0] prog_rdata, // Program memory word
  output qpc_data_port_type data_port, // Data memory strobes and address
  input wire logic [7:0] data_rdata, // Data memory read data
  output logic clock_out_pin, // Divided clock output
  output logic clock_out_pin_oe, // High while clock out is driven
  output qpc_bus_pins_type bus_pins, // External bus strobe pins
  output logic [IO_WIDTH-1:0] direction_registers, // 1 = pin is input
  output qpc_phase_type phase, // Current quadrature phase
  output logic device_in_reset, // Internal reset active
  output logic irq // Level interrupt
);

  // Register reads are 32 bits wide and branch targets are 13 bits
  if (IO_WIDTH < 1 || IO_WIDTH > 32 || PC_WIDTH < 8 || PC_WIDTH > 16)
  begin : g_bad_params
    $error("qpc_core: unsupported IO_WIDTH or PC_WIDTH");
  end

  typedef struct packed {
    logic [4:0] s1;
    logic [4:0] s2;
    logic [4:0] s3;
    logic [4:0] filt;
    logic osc_prev;
    logic rst;
    qpc_phase_type ph;
    logic [PC_WIDTH-1:0] pc;
    logic [15:0] fetch;
    logic [15:0] ilatch;
    logic [7:0] operand;
    logic flush;
    logic br_pend;
    logic [PC_WIDTH-1:0] br_tgt;
    logic rd_stb;
    logic wr_stb;
    logic [7:0] wdata;
    logic clkout;
    logic run;
    logic [3:0] cause;
    logic [2:0] irq_st;
    logic [2:0] irq_mk;
    logic [IO_WIDTH-1:0] dir;
    logic [31:0] scratch;
    qpc_osc_mode_type osc_sel;
    logic ext;
    logic ack;
    logic [31:0] rdata;
  } qpc_state_type;

  qpc_state_type st_q;
  qpc_state_type st_d;

  // Branch words: top three bits 110, target in the low bits
  function automatic logic is_branch(input logic [15:0] w);
    is_branch = (w[15:13] == 3'b110);
  endfunction

  // Add-literal words write their destination back
  function automatic logic writes_dest(input logic [15:0] w);
    writes_dest = (w[15:14] == 2'b01);
  endfunction

  function automatic logic [31:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wdat,
                                        input logic [3:0] sel);
    merge = (old & ~lane_mask(sel)) | (wdat & lane_mask(sel));
  endfunction

  logic osc_rise;
  logic rst_cause;
  logic tick;
  logic wb_hit;
  logic wb_wr;
  logic [31:0] wmerged;
  logic [2:0] irq_set;
  logic [31:0] rd_mux;

  always_comb
  begin
    st_d = st_q;
    irq_set = 3'h0;
    // Pins pass three flops; a level counts once stages two and three agree
    st_d.s1 = {osc_input_pin, supply_ok, brown_out_det, master_clear_pin_n, watchdog_reset};
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    for (int i = 0; i < 5; i++)
    begin
      if (st_q.s2[i] == st_q.s3[i])
      begin
        st_d.filt[i] = st_q.s3[i];
      end
    end
    st_d.osc_prev = st_q.filt[4];
    osc_rise = st_q.filt[4] & ~st_q.osc_prev;
    // Internal reset while supply is low, clear pin low, brown-out or watchdog
    rst_cause = ~st_q.filt[3] | st_q.filt[2] | ~st_q.filt[1] | st_q.filt[0];
    st_d.rst = rst_cause;
    st_d.rd_stb = 1'b0;
    st_d.wr_stb = 1'b0;
    tick = osc_rise & st_q.run & ~st_q.rst;

    if (rst_cause)
    begin
      st_d.ph = PH_ONE;
      st_d.pc = PC_WIDTH'(`QPC_PC_RESET);
      st_d.ilatch = `QPC_NOP_WORD;
      // The word fetched from the reset vector is kept, not flushed
      st_d.flush = 1'b0;
      st_d.br_pend = 1'b0;
      st_d.clkout = 1'b0;
      st_d.dir = '1;
      // Straps are caught while reset is held, after the async reset ends
      st_d.osc_sel = qpc_osc_mode_type'(oscillator_select_bits);
      st_d.ext = ext_exec_mode;
      if (!st_q.rst)
      begin
        // Cause is latched on the entering edge only
        if (~st_q.filt[3])
        begin
          st_d.cause = `QPC_CAUSE_POWERON;
        end
        else if (st_q.filt[2])
        begin
          st_d.cause[`QPC_CAUSE_POR_BIT] = 1'b1;
          st_d.cause[`QPC_CAUSE_BOR_BIT] = 1'b0;
          st_d.cause[`QPC_CAUSE_TO_BIT] = 1'b1;
          st_d.cause[`QPC_CAUSE_PD_BIT] = 1'b1;
        end
        else if (st_q.filt[0])
        begin
          st_d.cause[`QPC_CAUSE_TO_BIT] = 1'b0;
          st_d.cause[`QPC_CAUSE_PD_BIT] = 1'b1;
        end
      end
    end
    else
    begin
      if (st_q.rst)
      begin
        irq_set[`QPC_IRQ_RESET_BIT] = 1'b1;
      end
      if (tick)
      begin
        // Two-bit counter, one step per oscillator rising edge
        st_d.ph = qpc_phase_type'(st_q.ph + 2'b01);
        st_d.clkout = (st_q.ph == PH_TWO) || (st_q.ph == PH_THREE);
        case (st_q.ph)
          PH_FOUR:
          begin
            // Entering phase_one: advance PC and latch the prefetched word
            st_d.pc = st_q.br_pend ? st_q.br_tgt : PC_WIDTH'(st_q.pc + 1'b1);
            st_d.br_pend = 1'b0;
            st_d.ilatch = st_q.flush ? `QPC_NOP_WORD : st_q.fetch;
            st_d.flush = 1'b0;
          end
          PH_ONE:
          begin
            st_d.rd_stb = 1'b1;
          end
          PH_TWO:
          begin
            st_d.operand = data_rdata;
            st_d.wdata = data_rdata + {4'h0, st_q.ilatch[11:8]};
          end
          PH_THREE:
          begin
            // Entering phase_four: fetch next word while this one completes
            st_d.fetch = prog_rdata;
            st_d.wr_stb = writes_dest(st_q.ilatch);
            irq_set[`QPC_IRQ_CYCLE_BIT] = 1'b1;
            if (is_branch(st_q.ilatch))
            begin
              st_d.br_pend = 1'b1;
              st_d.br_tgt = PC_WIDTH'(st_q.ilatch[12:0]);
              st_d.flush = 1'b1;
              irq_set[`QPC_IRQ_BRANCH_BIT] = 1'b1;
            end
          end
          default:
          begin
            st_d.ph = PH_ONE;
          end
        endcase
      end
    end

    // Wishbone classic slave: registered ack one cycle after the request;
    // a write lands on the edge at which the master sees ack high
    wb_hit = wb_req.cyc & wb_req.stb & ~st_q.ack;
    wb_wr = wb_req.cyc & wb_req.stb & wb_req.we & st_q.ack;
    st_d.ack = wb_hit;
    wmerged = 32'h0;
    rd_mux = 32'h0;
    case (wb_req.adr)
      `QPC_ADR_CTRL:
      begin
        rd_mux[`QPC_CTRL_RUN_BIT] = st_q.run;
        wmerged = merge({31'h0, st_q.run}, wb_req.dat, wb_req.sel);
        if (wb_wr)
        begin
          st_d.run = wmerged[`QPC_CTRL_RUN_BIT];
        end
      end
      `QPC_ADR_CAUSE:
      begin
        rd_mux[3:0] = st_q.cause;
        // Software re-arms the power-on and brown-out flags by writing ones;
        // a reset entry in the same cycle wins over the write
        if (wb_wr && wb_req.sel[0] && !(rst_cause && !st_q.rst))
        begin
          if (wb_req.dat[`QPC_CAUSE_POR_BIT])
          begin
            st_d.cause[`QPC_CAUSE_POR_BIT] = 1'b1;
          end
          if (wb_req.dat[`QPC_CAUSE_BOR_BIT])
          begin
            st_d.cause[`QPC_CAUSE_BOR_BIT] = 1'b1;
          end
        end
      end
      `QPC_ADR_PC:
      begin
        rd_mux[PC_WIDTH-1:0] = st_q.pc;
      end
      `QPC_ADR_INSTR:
      begin
        rd_mux[15:0] = st_q.ilatch;
      end
      `QPC_ADR_IRQ_STAT:
      begin
        rd_mux[2:0] = st_q.irq_st;
        if (wb_wr && wb_req.sel[0])
        begin
          st_d.irq_st = st_q.irq_st & ~wb_req.dat[2:0];
        end
      end
      `QPC_ADR_IRQ_MASK:
      begin
        rd_mux[2:0] = st_q.irq_mk;
        if (wb_wr && wb_req.sel[0])
        begin
          st_d.irq_mk = wb_req.dat[2:0];
        end
      end
      `QPC_ADR_DIR:
      begin
        rd_mux[IO_WIDTH-1:0] = st_q.dir;
        wmerged = merge(32'(st_q.dir), wb_req.dat, wb_req.sel);
        if (wb_wr && !rst_cause)
        begin
          st_d.dir = wmerged[IO_WIDTH-1:0];
        end
      end
      `QPC_ADR_SCRATCH:
      begin
        rd_mux = st_q.scratch;
        if (wb_wr)
        begin
          st_d.scratch = merge(st_q.scratch, wb_req.dat, wb_req.sel);
        end
      end
      `QPC_ADR_MODE:
      begin
        rd_mux[`QPC_MODE_SEL_LSB +: 2] = st_q.osc_sel;
        rd_mux[`QPC_MODE_EXT_BIT] = st_q.ext;
        rd_mux[`QPC_MODE_PHASE_LSB +: 2] = st_q.ph;
      end
      default:
      begin
        rd_mux = 32'h0;
      end
    endcase
    if (wb_hit && !wb_req.we)
    begin
      st_d.rdata = rd_mux;
    end
    // Hardware set wins over a same-cycle software clear
    st_d.irq_st = st_d.irq_st | irq_set;
  end

  // Async reset is the power-on reset; the scratch word only clears here
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= '0;
      st_q.filt <= 5'h12;
      st_q.rst <= 1'b1;
      st_q.ph <= PH_ONE;
      st_q.pc <= PC_WIDTH'(`QPC_PC_RESET);
      st_q.fetch <= `QPC_NOP_WORD;
      st_q.ilatch <= `QPC_NOP_WORD;
      st_q.flush <= 1'b0;
      st_q.run <= `QPC_CTRL_RESET;
      st_q.cause <= `QPC_CAUSE_POWERON;
      st_q.irq_st <= `QPC_IRQ_RESET;
      st_q.irq_mk <= `QPC_IRQ_RESET;
      st_q.dir <= '1;
      st_q.osc_sel <= OSC_EXTERNAL_CLOCK;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign wb_rsp.ack = st_q.ack;
  assign wb_rsp.dat = st_q.rdata;
  assign prog_addr = st_q.pc;
  assign data_port.addr = st_q.ilatch[7:0];
  assign data_port.rd_stb = st_q.rd_stb;
  assign data_port.wr_stb = st_q.wr_stb;
  assign data_port.wdata = st_q.wdata;
  assign phase = st_q.ph;
  assign device_in_reset = st_q.rst;
  assign direction_registers = st_q.dir;
  // Crystal modes use the pin for the resonator, so it is only driven here
  assign clock_out_pin = st_q.clkout;
  assign clock_out_pin_oe = (st_q.osc_sel == OSC_EXTERNAL_CLOCK) ||
                            (st_q.osc_sel == OSC_RC);
  // During reset ALE parks low, OE and WR park high
  assign bus_pins.ale = ~st_q.rst & (st_q.ph == PH_ONE);
  assign bus_pins.oe_n = st_q.rst | (st_q.ph != PH_FOUR);
  assign bus_pins.wr_n = 1'b1;
  assign bus_pins.ale_oe = st_q.ext;
  assign bus_pins.oe_n_oe = st_q.ext;
  assign bus_pins.wr_n_oe = st_q.ext;
  assign irq = |(st_q.irq_st & st_q.irq_mk);

endmodule // qpc_core

// ### verilog/qpc_regs.svh
`ifndef QPC_REGS_SVH
`define QPC_REGS_SVH
`define QPC_ADR_CTRL 8'h00
`define QPC_ADR_CAUSE 8'h04
`define QPC_ADR_PC 8'h08
`define QPC_ADR_INSTR 8'h0c
`define QPC_ADR_IRQ_STAT 8'h10
`define QPC_ADR_IRQ_MASK 8'h14
`define QPC_ADR_DIR 8'h18
`define QPC_ADR_SCRATCH 8'h1c
`define QPC_ADR_MODE 8'h20
`define QPC_CTRL_RUN_BIT 0
`define QPC_CTRL_RESET 1'b1
`define QPC_CAUSE_POR_BIT 0
`define QPC_CAUSE_BOR_BIT 1
`define QPC_CAUSE_PD_BIT 2
`define QPC_CAUSE_TO_BIT 3
`define QPC_CAUSE_POWERON 4'hc
`define QPC_IRQ_CYCLE_BIT 0
`define QPC_IRQ_BRANCH_BIT 1
`define QPC_IRQ_RESET_BIT 2
`define QPC_IRQ_RESET 3'h0
`define QPC_NOP_WORD 16'h0000
`define QPC_PC_RESET 16'h0000
`define QPC_MODE_SEL_LSB 0
`define QPC_MODE_EXT_BIT 2
`define QPC_MODE_PHASE_LSB 4
`endif

// ### verilog/qpc_pkg.sv
package qpc_pkg;
  typedef enum logic [1:0] {
    PH_ONE = 2'b00,
    PH_TWO = 2'b01,
    PH_THREE = 2'b10,
    PH_FOUR = 2'b11
  } qpc_phase_type;

  typedef enum logic [1:0] {
    OSC_LOW_FREQ_CRYSTAL = 2'b00,
    OSC_STANDARD_CRYSTAL = 2'b01,
    OSC_EXTERNAL_CLOCK = 2'b10,
    OSC_RC = 2'b11
  } qpc_osc_mode_type;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } qpc_wb_req_type;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } qpc_wb_rsp_type;

  typedef struct packed {
    logic ale;
    logic ale_oe;
    logic oe_n;
    logic oe_n_oe;
    logic wr_n;
    logic wr_n_oe;
  } qpc_bus_pins_type;

  typedef struct packed {
    logic [7:0] addr;
    logic rd_stb;
    logic wr_stb;
    logic [7:0] wdata;
  } qpc_data_port_type;
endpackage

// ### testbench/qpc_monitor.sv
`timescale 1ns/1ns
module qpc_monitor
  import qpc_pkg::*;
#(
  parameter int IO_WIDTH = 8,
  parameter int PC_WIDTH = 16
)(
  input wire logic clk, // Clock
  input wire logic rstn, // Reset, active low
  input wire logic [PC_WIDTH-1:0] prog_addr, // Program counter
  input wire qpc_data_port_type data_port, // Data strobes
  input wire logic clock_out_pin, // Divided clock
  input wire qpc_bus_pins_type bus_pins, // Bus strobes
  input wire logic [IO_WIDTH-1:0] direction_registers, // 1 = input
  input wire qpc_phase_type phase, // Phase
  input wire logic device_in_reset // Internal reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_enter_two;
    phase == PH_TWO && $past(phase) == PH_ONE;
  endsequence
  sequence s_held_reset;
    device_in_reset && $past(device_in_reset);
  endsequence
  a_phase_step_order: assert property (!device_in_reset && phase != $past(phase)
    |-> phase == 2'($past(phase) + 2'h1)) else $error("phase skipped");
  a_reset_phase_one: assert property (s_held_reset |-> phase == PH_ONE)
    else $error("phase not frozen");
  a_reset_dir_input: assert property (s_held_reset |-> &direction_registers)
    else $error("direction not input");
  a_reset_bus_park: assert property (s_held_reset |-> !bus_pins.ale && bus_pins.oe_n
    && bus_pins.wr_n) else $error("strobes not parked");
  a_clkout_half_cycle: assert property (!device_in_reset |-> clock_out_pin == phase[1])
    else $error("clock out wrong");
  a_pc_step_one: assert property ($changed(prog_addr) |-> phase == PH_ONE)
    else $error("pc moved off phase one");
  a_read_on_two: assert property (s_enter_two |-> data_port.rd_stb ##1 !data_port.rd_stb)
    else $error("no operand read");
  a_write_on_four: assert property (data_port.wr_stb |-> phase == PH_FOUR
    && $past(phase) == PH_THREE ##1 !data_port.wr_stb) else $error("write off phase four");
endmodule // qpc_monitor
bind qpc_core qpc_monitor #(.IO_WIDTH(IO_WIDTH), .PC_WIDTH(PC_WIDTH)) i_monitor (.clk, .rstn,
  .prog_addr, .data_port, .clock_out_pin, .bus_pins, .direction_registers, .phase,
  .device_in_reset);

// ### testbench/qpc_osc_model.sv
`timescale 1ns/1ns
module qpc_osc_model (
  input wire logic clk, // Bench clock
  input wire logic run, // Oscillator running
  input wire logic [4:0] half, // Half period in clocks
  output logic osc // Oscillator output
);
  logic [4:0] cnt;
  // Stands low until started, like a source that has not begun to swing
  always @(posedge clk)
  begin
    if (!run)
    begin
      cnt <= 5'h0;
      osc <= 1'b0;
    end
    else if (cnt + 5'h1 >= half)
    begin
      cnt <= 5'h0;
      osc <= !osc;
    end
    else
      cnt <= cnt + 5'h1;
  end
endmodule // qpc_osc_model

// ### testbench/quad_phase_clock_pipeline_reset_bench.sv
`timescale 1ns/1ns
`include "qpc_regs.svh"
module quad_phase_clock_pipeline_reset_bench
  import qpc_pkg::*;
;
  logic clk = 0, rstn = 0, run = 0, fixed = 0, fl, p;
  logic supply_ok = 1, brown_out_det = 0, master_clear_pin_n = 1, watchdog_reset = 0;
  logic ext_exec_mode = 1, osc_input_pin, clock_out_pin, clock_out_pin_oe, device_in_reset, irq;
  logic [1:0] oscillator_select_bits = 2'b10;
  logic [4:0] half = 5'h0a;
  logic [15:0] prog_addr, prog_rdata = '0, lat, fet, epc;
  logic [15:0] mem [64];
  logic [7:0] data_rdata = '0, direction_registers, rv;
  logic [31:0] q, s;
  logic [3:0] cx [4] = '{4'hf, 4'h7, 4'hd, 4'hc};
  qpc_wb_req_type wb_req = '0;
  qpc_wb_rsp_type wb_rsp;
  qpc_data_port_type data_port;
  qpc_bus_pins_type bus_pins;
  qpc_phase_type phase, pph = PH_ONE;
  int miscompares = 0, n_tests = 0, k;
  always #25 clk = ~clk;
  qpc_core i_dut (.clk, .rstn, .wb_req, .wb_rsp, .osc_input_pin, .supply_ok, .brown_out_det,
    .master_clear_pin_n, .watchdog_reset, .oscillator_select_bits, .ext_exec_mode, .prog_addr,
    .prog_rdata, .data_port, .data_rdata, .clock_out_pin, .clock_out_pin_oe, .bus_pins,
    .direction_registers, .phase, .device_in_reset, .irq);
  qpc_osc_model i_osc (.clk, .run, .half, .osc(osc_input_pin));
  function automatic logic [7:0] wsum(input logic [15:0] w, input logic [7:0] r);
    return r + 8'(w[11:8]);
  endfunction
  task close_out;
    $display("tests %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      miscompares++;
      $display("mismatch %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic hang_check(input logic ok);
    if (!ok)
    begin
      chk(32'h0, 32'h1);
      close_out();
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d = '0);
    int i;
    @(posedge clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: d};
    i = 0;
    do
      @(posedge clk);
    while (wb_rsp.ack !== 1'b1 && ++i < 20);
    q = wb_rsp.dat;
    wb_req <= '0;
    hang_check(wb_rsp.ack === 1'b1);
  endtask
  task automatic wait_rst(input logic v);
    for (int i = 0; i < 60 && device_in_reset !== v; i++)
      @(posedge clk);
    hang_check(device_in_reset === v);
  endtask
  task automatic wait_rise(output int n);
    n = 0;
    p = 1'b1;
    while (!(p === 1'b0 && clock_out_pin === 1'b1) && n < 400)
    begin
      p = clock_out_pin;
      @(posedge clk);
      n++;
    end
    hang_check(n < 400);
  endtask
  always @(posedge clk)
  begin
    prog_rdata <= mem[prog_addr[5:0]];
    if (phase == PH_ONE)
      data_rdata <= 8'($urandom);
    if (phase == PH_FOUR && !fixed)
      half <= 5'(9 + $urandom % 8);
  end
  // Reference pipeline, stepped by the phase the design shows
  always @(negedge clk)
  begin
    if (device_in_reset !== 1'b0)
    begin
      epc = '0;
      lat = '0;
      fl = 0;
    end
    else if (phase != pph)
      case (phase)
        PH_ONE:
        begin
          epc = fl ? {3'h0, lat[12:0]} : epc + 16'h1;
          lat = fl ? 16'h0 : fet;
          fl = 0;
          chk(prog_addr, epc);
        end
        PH_TWO: chk({data_port.rd_stb, data_port.addr}, {1'b1, lat[7:0]});
        PH_THREE: rv = data_rdata;
        default:
        begin
          fet = mem[prog_addr[5:0]];
          fl = lat[15:13] == 3'b110;
          chk(data_port.wr_stb, lat[15:14] == 2'b01);
          if (data_port.wr_stb === 1'b1)
            chk(data_port.wdata, wsum(lat, rv));
        end
      endcase
    pph = phase;
  end
  initial
  begin
    k = $urandom(32'hb019);
    for (k = 0; k < 64; k++)
      mem[k] = ($urandom % 4 == 0) ? 16'h0 : {2'b01, 14'($urandom)};
    mem[20] = {3'b110, 13'd21};
    mem[40] = {3'b110, 13'($urandom % 40)};
    // Sits in the branch shadow, so it must never be taken
    mem[41] = {3'b110, 13'd50};
    repeat (2) @(posedge clk);
    rstn <= 1;
    run <= 1;
    wait_rst(0);
    wb(0, `QPC_ADR_CAUSE);
    chk(q, 32'hc);
    wb(1, `QPC_ADR_CAUSE, 32'h3);
    wb(0, `QPC_ADR_CAUSE);
    chk(q, 32'hf);
    wb(0, 8'h40);
    chk(q, 32'h0);
    fixed <= 1;
    // Random half periods must be off first, or they could overwrite this
    @(posedge clk);
    half <= 5'h0a;
    wait_rise(k);
    wait_rise(k);
    wait_rise(k);
    chk(k, 8 * 10);
    fixed <= 0;
    repeat (6000) @(posedge clk);
    wb(1, `QPC_ADR_CTRL, 32'h0);
    wb(0, `QPC_ADR_PC);
    chk(q, {16'h0, epc});
    wb(0, `QPC_ADR_INSTR);
    chk(q, {16'h0, lat});
    wb(0, `QPC_ADR_IRQ_STAT);
    chk(q[2], 1'b1);
    chk(irq, 1'b0);
    wb(1, `QPC_ADR_IRQ_MASK, 32'h4);
    wb(0, `QPC_ADR_IRQ_MASK);
    chk(irq, 1'b1);
    wb(1, `QPC_ADR_IRQ_STAT, 32'h7);
    wb(0, `QPC_ADR_IRQ_STAT);
    chk(q, 32'h0);
    chk(irq, 1'b0);
    wb(1, `QPC_ADR_CTRL, 32'h1);
    for (k = 0; k < 4; k++)
    begin
      s = $urandom;
      wb(1, `QPC_ADR_SCRATCH, s);
      wb(1, `QPC_ADR_DIR, 32'h0);
      @(posedge clk);
      oscillator_select_bits <= 2'(k);
      ext_exec_mode <= 1'($urandom);
      master_clear_pin_n <= k != 0;
      watchdog_reset <= k == 1;
      brown_out_det <= k == 2;
      supply_ok <= k != 3;
      wait_rst(1);
      repeat (8) @(posedge clk);
      chk(direction_registers, 8'hff);
      chk(phase, PH_ONE);
      master_clear_pin_n <= 1;
      watchdog_reset <= 0;
      brown_out_det <= 0;
      supply_ok <= 1;
      wait_rst(0);
      wb(0, `QPC_ADR_CAUSE);
      chk(q, cx[k]);
      wb(0, `QPC_ADR_MODE);
      chk(q[2:0], {ext_exec_mode, oscillator_select_bits});
      chk(clock_out_pin_oe, oscillator_select_bits[1]);
      chk(bus_pins.ale_oe, ext_exec_mode);
      wb(0, `QPC_ADR_SCRATCH);
      if (k < 3)
        chk(q, s);
      repeat (600) @(posedge clk);
    end
    close_out();
  end
endmodule // quad_phase_clock_pipeline_reset_bench
